// ### include/rfa_map.svh
// Constant map of the fault and status annunciator: timing, fault indices, register offsets.
`ifndef RFA_MAP_SVH
`define RFA_MAP_SVH
`define RFA_CLK_NS 10
`define RFA_TICK_US 100
`define RFA_SLOW_MS 1000
`define RFA_FAST_MS 333
`define RFA_GAP_MS 2000
`define RFA_PRE_S 10
`define RFA_SYNC_TO 250
`define RFA_P60_LO 150
`define RFA_P60_HI 183
`define RFA_P50_HI 220
`define RFA_HIST 50
`define RFA_NFLT 11
`define RFA_NFAST 5
`define RFA_LATCH_MASK 11'h06D
`define RFA_F_OT 1
`define RFA_F_PRE 9
`define RFA_CTRL_RST 2'h0
`define RFA_CTRL_SEL 0
`define RFA_CTRL_DISP 1
`define RFA_OKAY 2'h0
`define RFA_SLVERR 2'h2
`define RFA_A_CTRL 8'h00
`define RFA_A_STAT 8'h04
`define RFA_A_UPT 8'h08
`define RFA_A_ELIFE 8'h0C
`define RFA_A_EUSER 8'h10
`define RFA_A_VIEW 8'h14
`define RFA_A_RECF 8'h18
`define RFA_A_RECT 8'h1C
`define RFA_A_HCNT 8'h20
`endif

// ### include/rfa_pkg.sv
// Types shared by the fault and status annunciator.
`include "rfa_map.svh"
package rfa_pkg;
  typedef enum logic [2:0] {SCR_METER, SCR_FAULTS, SCR_FREC, SCR_ENERGY, SCR_ERESET} rfa_screen_t;
  typedef enum logic [1:0] {BK_IDLE, BK_ON, BK_OFF, BK_GAP} rfa_blink_t;
  typedef struct packed {
    logic awvalid; logic [31:0] awaddr; logic wvalid; logic [31:0] wdata; logic [3:0] wstrb;
    logic bready; logic arvalid; logic [31:0] araddr; logic rready;
  } rfa_axil_req_t;
  typedef struct packed {
    logic awready; logic wready; logic bvalid; logic [1:0] bresp;
    logic arready; logic rvalid; logic [31:0] rdata; logic [1:0] rresp;
  } rfa_axil_rsp_t;
  typedef struct packed {
    logic [18:0] sy1; logic [18:0] sy2;
    logic [7:0] sh1; logic [7:0] sh2; logic [7:0] db; logic [7:0] dbp;
    logic [13:0] tdiv; logic [13:0] secc; logic [31:0] uptime;
    logic [16:0] pcnt; logic pdone;
    logic zcp; logic [8:0] per; logic locked; logic seen; logic line60; logic ffail;
    logic [10:0] lat; logic [10:0] fault;
    logic [`RFA_HIST-1:0][42:0] hist; logic [5:0] wp; logic [6:0] cnt;
    logic epp; logic [31:0] e_life; logic [31:0] e_user;
    rfa_screen_t scr; logic [5:0] rec_sel; logic [3:0] item; logic [3:0] fview;
    rfa_blink_t bk; logic [3:0] bidx; logic [2:0] bn; logic slow; logic [14:0] btmr;
    logic ready; logic sel; logic red; logic yel; logic [1:0] ctrl;
    logic awg; logic [7:0] awa; logic wg; logic [31:0] wd; logic [3:0] ws;
    logic bv; logic [1:0] bresp; logic rv; logic [31:0] rd; logic [1:0] rresp;
  } rfa_state_t;
endpackage

// ### hw/rfa_top.sv
// Fault latching, status contacts, lamps, blink codes, display navigation and records.
//
// Register access over AXI4-Lite and the placing of the registers are this design's own decisions.
`timescale 1ns/10ps
`include "rfa_map.svh"
// Notes on behaviour
// - In over-temperature duty the selectable contact opens while over-temperature is present.
// - In regen-active duty the selectable contact closes while regenerating.
// - Output selection resets to over-temperature duty.
// - Line frequency of 50 or 60 Hz is detected and tracked automatically.
// - Yellow lamp follows regeneration; green lamp is on whenever powered.
// - With display, red lamp lights on any fault or enable inactive.
// - Without display, red is solid when disabled and blinks the present fault.
// - Fast counts 1-5 and slow counts 1-6 name the eleven faults.
// - Slow codes flash once per second, fast codes three times per second.
// - Latching faults hold until enable toggles; frequency detect failure holds until power-down; others clear with their condition.
// - Any active fault opens the ready contact.
// - Display units keep the fifty latest fault states, dropping the oldest.
// - Each record holds all active faults plus powered time of occurrence.
// - Disabled unit without display, with recall asserted, blinks every fault of the latest state.
// - Feedback undervoltage latches until enable is toggled.
// - Over-temperature clears by itself when temperature is safe again.
// - Lifetime and resettable energy totals; enter on reset screen zeroes resettable.
// - Metering, energy records and reset screens navigate by left, right, up, down.
// - Faults screen and fault records navigate; cancel returns to faults.
// - The faults screen cycles through every present fault.
// - A rising enable transition clears latched faults.
// - Ready closes only when enabled, powered and fault-free.
// - Precharge-incomplete fault is present for ten seconds after power-up.
module rfa_top #(
  parameter int TICK_CYC = `RFA_TICK_US * 1000 / `RFA_CLK_NS,
  parameter int SEC_TICKS = 1000000 / `RFA_TICK_US
) (
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // Register bus.
  input wire rfa_pkg::rfa_axil_req_t s_axil_req,
  output rfa_pkg::rfa_axil_rsp_t s_axil_rsp,
  // Operator terminals and front panel buttons.
  input wire logic enable_terminal,
  input wire logic fault_recall_terminal,
  input wire logic [5:0] button_n_unused_free,
  // Power stage.
  input wire logic line_zero_cross,
  input wire logic energy_pulse,
  input wire logic regen_active,
  input wire logic [7:0] pstage_fault,
  // Contacts and lamps.
  output logic ready_contact_terminal,
  output logic selectable_status_contact,
  output logic lamp_green,
  output logic lamp_yellow,
  output logic lamp_red
);
  import rfa_pkg::*;

  // ----------------------------------------------------------------
  // Derived tick counts
  // ----------------------------------------------------------------
  // Seconds-based intervals scale with SEC_TICKS; the line period window stays in ticks.
  localparam int SEC_T = SEC_TICKS;
  localparam int SLOW_H = `RFA_SLOW_MS * SEC_T / 1000 / 2;
  localparam int FAST_H = `RFA_FAST_MS * SEC_T / 1000 / 2;
  localparam int GAP_T = `RFA_GAP_MS * SEC_T / 1000;
  localparam int PRE_T = `RFA_PRE_S * SEC_T;

  rfa_state_t s, n;
  logic tick, sec, en_rise, zc, ep, recall, disp, eclr;
  logic [5:0] btn;
  logic [7:0] stab;
  logic [10:0] raw, newf, src, recf;
  logic [4:0] f;
  logic [8:0] per;

  // Next set bit after cur (or before, when dn), wrapping; returns {found, index}.
  function automatic logic [4:0] scan(input logic [10:0] v, input logic [3:0] cur,
                                      input logic dn);
    int j;
    logic [4:0] r;
    r = '0;
    for (int k = `RFA_NFLT; k >= 1; k--)
    begin
      j = (int'(cur) + (dn ? `RFA_NFLT - k : k)) % `RFA_NFLT;
      if (v[j])
        r = {1'b1, 4'(j)};
    end
    return r;
  endfunction

  // History slot of the record off places older than the newest.
  function automatic logic [5:0] raddr(input logic [5:0] wp, input logic [5:0] off);
    int a;
    a = int'(wp) + `RFA_HIST - 1 - int'(off);
    if (a >= `RFA_HIST)
      a = a - `RFA_HIST;
    return 6'(a);
  endfunction

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  // All behaviour is computed here from the registered state, the raw pins and the bus request.
  always_comb
  begin
    n = s;
    stab = '0;
    f = '0;
    per = '0;
    eclr = 1'b0;
    n.sy1 = {pstage_fault, regen_active, energy_pulse, line_zero_cross,
             ~button_n_unused_free, fault_recall_terminal, enable_terminal};
    n.sy2 = s.sy1;
    tick = (s.tdiv == 14'(TICK_CYC - 1));
    n.tdiv = tick ? '0 : s.tdiv + 14'h1;
    sec = tick && (s.secc == 14'(SEC_T - 1));
    if (tick)
      n.secc = sec ? '0 : s.secc + 14'h1;
    if (sec)
      n.uptime = s.uptime + 32'h1;
    if (tick)
    begin
      stab = ~(s.sy2[7:0] ^ s.sh1) & ~(s.sy2[7:0] ^ s.sh2);
      n.sh1 = s.sy2[7:0];
      n.sh2 = s.sh1;
      n.db = (s.db & ~stab) | (s.sy2[7:0] & stab);
    end
    n.dbp = s.db;
    en_rise = s.db[0] & ~s.dbp[0];
    btn = s.db[7:2] & ~s.dbp[7:2];
    if (tick && !s.pdone)
    begin
      if (s.pcnt == 17'(PRE_T - 1))
        n.pdone = 1'b1;
      else
        n.pcnt = s.pcnt + 17'h1;
    end
    zc = s.sy2[8] & ~s.zcp;
    n.zcp = s.sy2[8];
    if (zc)
    begin
      per = s.per;
      n.per = '0;
      if (per >= 9'(`RFA_P60_LO) && per <= 9'(`RFA_P60_HI))
        {n.locked, n.line60} = 2'b11;
      else if (per > 9'(`RFA_P60_HI) && per <= 9'(`RFA_P50_HI))
        {n.locked, n.line60} = 2'b10;
      else
        n.locked = 1'b0;
    end
    else if (tick)
    begin
      if (s.per != '1)
        n.per = s.per + 9'h1;
      if (s.per >= 9'(`RFA_SYNC_TO))
        n.locked = 1'b0;
    end
    n.seen = s.seen | n.locked;
    // Frequency detect failure holds until power-down.
    if (s.pdone && !s.seen)
      n.ffail = 1'b1;
    // fault vector order is blink order
    raw = {s.ffail, ~s.pdone, s.sy2[18:15], s.seen & ~s.locked, s.sy2[14:11]};
    n.lat = (s.lat & ~{11{en_rise}}) | (raw & `RFA_LATCH_MASK);
    n.fault = n.lat | raw;
    newf = n.fault & ~s.fault;
    newf[`RFA_F_PRE] = 1'b0;
    if (|newf)
    begin
      n.hist[s.wp] = {n.fault, s.uptime};
      n.wp = (s.wp == 6'(`RFA_HIST - 1)) ? '0 : s.wp + 6'h1;
      if (s.cnt < 7'(`RFA_HIST))
        n.cnt = s.cnt + 7'h1;
    end
    ep = s.sy2[9] & ~s.epp;
    n.epp = s.sy2[9];
    n.e_life = s.e_life + {31'h0, ep};
    disp = s.ctrl[`RFA_CTRL_DISP];
    recf = s.hist[raddr(s.wp, s.rec_sel)][42:32];
    if (disp && s.scr == SCR_ERESET && btn[5])
      eclr = 1'b1;
    n.e_user = eclr ? {31'h0, ep} : s.e_user + {31'h0, ep};
    if (disp)
    begin
      case (s.scr)
        SCR_METER:
        begin
          if (btn[2] | btn[3])
            n.scr = SCR_FAULTS;
          else if (btn[1])
            n.scr = SCR_ENERGY;
        end
        SCR_ENERGY:
        begin
          if (btn[0])
            n.scr = SCR_METER;
          else if (btn[1])
            n.scr = SCR_ERESET;
        end
        SCR_ERESET:
        begin
          if (btn[0])
            n.scr = SCR_ENERGY;
        end
        SCR_FAULTS:
        begin
          if (btn[2] | btn[3])
            n.scr = SCR_METER;
          else if (btn[1])
          begin
            n.scr = SCR_FREC;
            n.rec_sel = '0;
          end
        end
        SCR_FREC:
        begin
          if (btn[4])
            n.scr = SCR_FAULTS;
          else if (btn[0] && s.rec_sel != '0)
            n.rec_sel = s.rec_sel - 6'h1;
          else if (btn[1] && 7'(s.rec_sel) + 7'h1 < s.cnt)
            n.rec_sel = s.rec_sel + 6'h1;
          else if (btn[2] | btn[3])
          begin
            f = scan(recf, s.item, btn[2]);
            if (f[4])
              n.item = f[3:0];
          end
        end
        default: n.scr = SCR_METER;
      endcase
    end
    // faults screen scrolls once a second
    if (sec)
    begin
      f = scan(s.fault, s.fview, 1'b0);
      if (f[4])
        n.fview = f[3:0];
    end
    // recall source is the newest record
    recall = ~s.db[0] & s.db[1] & (s.cnt != '0);
    src = recall ? s.hist[raddr(s.wp, 6'h0)][42:32] : s.fault;
    case (s.bk)
      BK_IDLE:
      begin
        if (|src)
        begin
          f = scan(src, s.bidx, 1'b0);
          n.bidx = f[3:0];
          n.slow = (f[3:0] >= 4'(`RFA_NFAST));
          n.bn = n.slow ? 3'(f[3:0] - 4'(`RFA_NFAST - 1)) : 3'(f[3:0] + 4'h1);
          n.btmr = n.slow ? 15'(SLOW_H) : 15'(FAST_H);
          n.bk = BK_ON;
        end
      end
      BK_ON, BK_OFF, BK_GAP:
      begin
        if (tick && s.btmr > 15'h1)
          n.btmr = s.btmr - 15'h1;
        else if (tick)
        begin
          n.btmr = s.slow ? 15'(SLOW_H) : 15'(FAST_H);
          if (s.bk == BK_ON)
            n.bk = BK_OFF;
          else if (s.bk == BK_GAP)
            n.bk = BK_IDLE;
          else if (s.bn == 3'h1)
          begin
            n.bk = BK_GAP;
            n.btmr = 15'(GAP_T);
          end
          else
          begin
            n.bn = s.bn - 3'h1;
            n.bk = BK_ON;
          end
        end
      end
      default: n.bk = BK_IDLE;
    endcase
    n.ready = s.db[0] & s.pdone & ~|s.fault;
    n.sel = s.ctrl[`RFA_CTRL_SEL] ? s.sy2[10] : ~s.fault[`RFA_F_OT];
    n.yel = s.sy2[10];
    if (disp)
      n.red = (|s.fault) | ~s.db[0];
    else if (recall || s.db[0])
      n.red = (s.bk == BK_ON);
    else
      n.red = 1'b1;
    // AXI4-Lite write: address and data taken in either order.
    if (s_axil_req.awvalid && s_axil_rsp.awready)
    begin
      n.awg = 1'b1;
      n.awa = (s_axil_req.awaddr[31:8] == '0) ? s_axil_req.awaddr[7:0] : 8'hFF;
    end
    if (s_axil_req.wvalid && s_axil_rsp.wready)
    begin
      n.wg = 1'b1;
      n.wd = s_axil_req.wdata;
      n.ws = s_axil_req.wstrb;
    end
    if (s.awg && s.wg)
    begin
      {n.awg, n.wg, n.bv} = 3'b001;
      n.bresp = (s.awa == `RFA_A_CTRL) ? `RFA_OKAY : `RFA_SLVERR;
      if (s.awa == `RFA_A_CTRL && s.ws[0])
        n.ctrl = s.wd[1:0];
    end
    if (s.bv && s_axil_req.bready)
      n.bv = 1'b0;
    if (s.rv && s_axil_req.rready)
      n.rv = 1'b0;
    // AXI4-Lite read: one outstanding, answered the next cycle.
    if (s_axil_req.arvalid && !s.rv)
    begin
      n.rv = 1'b1;
      n.rresp = `RFA_OKAY;
      n.rd = '0;
      case (s_axil_req.araddr[31:8] == '0 ? s_axil_req.araddr[7:0] : 8'hFF)
        `RFA_A_CTRL: n.rd = {30'h0, s.ctrl};
        `RFA_A_STAT: n.rd = {12'h0, s.line60, s.seen, s.db[0], s.ready, 5'h0, s.fault};
        `RFA_A_UPT: n.rd = s.uptime;
        `RFA_A_ELIFE: n.rd = s.e_life;
        `RFA_A_EUSER: n.rd = s.e_user;
        `RFA_A_VIEW: n.rd = {4'h0, s.fview, 4'h0, s.item, 2'h0, s.rec_sel, 5'h0, s.scr};
        `RFA_A_RECF: n.rd = {21'h0, recf};
        `RFA_A_RECT: n.rd = s.hist[raddr(s.wp, s.rec_sel)][31:0];
        `RFA_A_HCNT: n.rd = {25'h0, s.cnt};
        default: n.rresp = `RFA_SLVERR;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  // Synchronous reset; all-zero also means over-temperature duty and no display.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s <= '0;
      s.ctrl <= `RFA_CTRL_RST;
    end
    else
      s <= n;
  end

  // Bus answers and pins.
  assign s_axil_rsp.awready = ~s.awg & ~s.bv;
  assign s_axil_rsp.wready = ~s.wg & ~s.bv;
  assign s_axil_rsp.bvalid = s.bv;
  assign s_axil_rsp.bresp = s.bresp;
  assign s_axil_rsp.arready = ~s.rv;
  assign s_axil_rsp.rvalid = s.rv;
  assign s_axil_rsp.rdata = s.rd;
  assign s_axil_rsp.rresp = s.rresp;
  assign ready_contact_terminal = s.ready;
  assign selectable_status_contact = s.sel;
  assign lamp_green = 1'b1;
  assign lamp_yellow = s.yel;
  assign lamp_red = s.red;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  AST_READY: assert property (s.ready |-> $past(s.db[0] && s.fault == '0))
    else $error("ready closed while disabled or faulted");
  AST_FLT_READY: assert property (s.fault != '0 |=> !s.ready)
    else $error("ready closed with a fault");
  AST_OT_SEL: assert property (!s.ctrl[0] && s.fault[1] |=> !s.sel)
    else $error("over-temperature contact not open");
  AST_RA_SEL: assert property (s.ctrl[0] |=> s.sel == $past(s.sy2[10]))
    else $error("regen-active contact wrong");
  AST_LATCH: assert property (s.fault[0] && !en_rise |=> s.fault[0])
    else $error("latched fault dropped without enable edge");
  AST_CLEAR: assert property (en_rise && !raw[0] |=> !s.lat[0])
    else $error("latched fault not cleared on enable edge");
  AST_NOLATCH: assert property (!raw[1] |=> !s.fault[1])
    else $error("over-temperature did not self-clear");
  AST_RED_DISP: assert property (disp && s.fault != '0 |=> s.red)
    else $error("red lamp dark with fault on display unit");
  AST_RED_SOLID: assert property ((!disp && !s.db[0] && !s.db[1]) [*2] |-> s.red [*2])
    else $error("red lamp not solid while disabled");
  AST_HIST: assert property (s.cnt <= 7'(`RFA_HIST))
    else $error("history count exceeds depth");
  AST_ERESET: assert property (eclr |=> s.e_user <= 32'h1)
    else $error("resettable energy not zeroed");
endmodule // rfa_top

// ### dv/rfa_plant_model.sv
// Plant controller model that drives the enable and fault recall terminals.
`timescale 1ns/10ps
module rfa_plant_model (
  // Clock.
  input wire logic aclk,
  // Requests from the bench.
  input wire logic want_enable,
  input wire logic want_recall,
  // Terminals towards the unit.
  output logic enable_terminal,
  output logic fault_recall_terminal
);
  logic en_r = 1'b0;
  logic rc_r = 1'b0;

  // disable before recall
  // A recall request holds enable low, and recall is only raised once enable is already low.
  // This keeps the operator order even if the bench asks for both at the same edge.
  always_ff @(posedge aclk)
  begin
    en_r <= want_enable & ~want_recall;
    rc_r <= want_recall & ~en_r;
  end

  assign enable_terminal = en_r;
  assign fault_recall_terminal = rc_r;
endmodule // rfa_plant_model

// ### dv/testbench.sv
// Self-checking bench of the fault and status annunciator.
`timescale 1ns/10ps
`include "rfa_map.svh"
module testbench;
  import rfa_pkg::*;
  // --------------------------------------------------------------------------
  // Signals and instances
  // --------------------------------------------------------------------------
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  rfa_axil_req_t req = '0;
  rfa_axil_rsp_t rsp;
  logic want_en = 1'b1;
  logic want_rc = 1'b0;
  logic en_t, rc_t, rdy, sel, lg, ly, lr;
  logic [5:0] btn_n = 6'h3F;
  logic zc = 1'b0;
  logic epulse = 1'b0;
  logic regen = 1'b0;
  logic [7:0] pf = 8'h00;
  int mismatches = 0;
  int samples_checked = 0;
  int cyc = 0;
  int zc_per = 166;
  int w, n, i;
  logic [31:0] rnd = 32'h14D7;
  logic [31:0] rd, v0, v1;
  logic [1:0] rr;
  int btn[13] = '{2, 3, 3, 1, 4, 2, 1, 0, 1, 1, 5, 0, 0};
  int scr[13] = '{1, 0, 1, 2, 1, 0, 3, 0, 3, 4, 4, 3, 0};

  // One tick per clock and a short second keep the whole run well inside the cycle budget.
  localparam int SEC_C = 1000;
  localparam int GAP_C = `RFA_GAP_MS * SEC_C / 1000;
  rfa_top #(.TICK_CYC(1), .SEC_TICKS(SEC_C)) rfa_top_inst (.aclk(aclk), .aresetn(aresetn),
    .s_axil_req(req),
    .s_axil_rsp(rsp), .enable_terminal(en_t), .fault_recall_terminal(rc_t),
    .button_n_unused_free(btn_n), .line_zero_cross(zc), .energy_pulse(epulse),
    .regen_active(regen), .pstage_fault(pf), .ready_contact_terminal(rdy),
    .selectable_status_contact(sel), .lamp_green(lg), .lamp_yellow(ly), .lamp_red(lr));
  rfa_plant_model rfa_plant_model_inst (.aclk(aclk), .want_enable(want_en),
    .want_recall(want_rc), .enable_terminal(en_t), .fault_recall_terminal(rc_t));

  // Clock, line zero crossings and the run limit.
  initial
  begin
    forever #5 aclk = ~aclk;
  end
  always
  begin
    repeat (zc_per / 2) @(posedge aclk);
    zc <= ~zc;
  end
  always @(posedge aclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 60000)
    begin
      mismatches++;
      report_and_stop();
    end
  end

  // --------------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  // Flash count and half period of the blink code of fault index idx.
  function automatic int exp_flashes(input int idx);
    return idx < `RFA_NFAST ? idx + 1 : idx - `RFA_NFAST + 1;
  endfunction
  function automatic int exp_width(input int idx);
    return (idx < `RFA_NFAST ? `RFA_FAST_MS : `RFA_SLOW_MS) * SEC_C / 1000 / 2;
  endfunction
  task automatic chk_word(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[ERR] %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  task automatic chk_pin(input string what, input logic exp, input logic got);
    chk_word(what, {31'h0, exp}, {31'h0, got});
  endtask
  task automatic wait_cyc(input int k);
    repeat (k) @(posedge aclk);
  endtask
  // Bus write: address and data offered together, each dropped once taken.
  task automatic axw(input logic [31:0] a, input logic [31:0] d);
    @(posedge aclk);
    req.awaddr <= a;
    req.wdata <= d;
    req.wstrb <= 4'hF;
    req.awvalid <= 1'b1;
    req.wvalid <= 1'b1;
    req.bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (req.awvalid && rsp.awready === 1'b1)
        req.awvalid <= 1'b0;
      if (req.wvalid && rsp.wready === 1'b1)
        req.wvalid <= 1'b0;
    end
    while (rsp.bvalid !== 1'b1);
    rr = rsp.bresp;
    req.bready <= 1'b0;
  endtask
  task automatic axr(input logic [31:0] a);
    @(posedge aclk);
    req.araddr <= a;
    req.arvalid <= 1'b1;
    req.rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (req.arvalid && rsp.arready === 1'b1)
        req.arvalid <= 1'b0;
    end
    while (rsp.rvalid !== 1'b1);
    rd = rsp.rdata;
    rr = rsp.rresp;
    req.rready <= 1'b0;
  endtask
  task automatic chk_reg(input string what, input logic [31:0] a, input logic [31:0] m,
      input logic [31:0] exp);
    axr(a);
    chk_word(what, exp, rd & m);
  endtask
  task automatic press(input int b);
    @(posedge aclk);
    btn_n[b] <= 1'b0;
    wait_cyc(10);
    btn_n[b] <= 1'b1;
    wait_cyc(10);
  endtask
  task automatic set_en(input logic v);
    @(posedge aclk);
    want_en <= v;
    wait_cyc(20);
  endtask
  // Width of the next complete red flash.
  task automatic flash_width(output int width);
    width = 0;
    while (lr !== 1'b0)
      @(posedge aclk);
    while (lr !== 1'b1)
      @(posedge aclk);
    while (lr === 1'b1)
    begin
      @(posedge aclk);
      width++;
    end
  endtask
  // Waits out a dark stretch longer than thr, then counts one group of flashes.
  task automatic blink_group(input int thr, output int width, output int cnt);
    int lo;
    logic p;
    lo = 0;
    width = 0;
    cnt = 0;
    p = 1'b0;
    while (lo <= thr)
    begin
      @(posedge aclk);
      lo = (lr === 1'b1) ? 0 : lo + 1;
    end
    lo = 0;
    while (cnt == 0 || lo <= thr)
    begin
      @(posedge aclk);
      if (lr === 1'b1 && !p)
        cnt++;
      if (lr === 1'b1 && cnt == 1)
        width++;
      p = (lr === 1'b1);
      lo = p ? 0 : lo + 1;
    end
  endtask
  task automatic test_done(input string name);
    $display("test %s finished at cycle %0d", name, cyc);
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // --------------------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------------------
  initial
  begin
    wait_cyc(2);
    aresetn <= 1'b1;
    chk_pin("green", 1'b1, lg);
    chk_reg("ctrl", `RFA_A_CTRL, 32'h3, 32'h0);
    chk_reg("precharge", `RFA_A_STAT, 32'h200, 32'h200);
    chk_pin("ready", 1'b0, rdy);
    chk_pin("sel", 1'b1, sel);
    axw(`RFA_A_STAT, 32'h1);
    chk_word("bresp", `RFA_SLVERR, rr);
    axr(32'h24);
    chk_word("rresp", `RFA_SLVERR, rr);
    test_done("reset");
    // The precharge fault alone blinks as a slow code.
    flash_width(w);
    chk_word("slow_width", exp_width(`RFA_F_PRE), w);
    chk_reg("line60", `RFA_A_STAT, 32'hC0000, 32'hC0000);
    zc_per = 200;
    wait_cyc(3000);
    chk_reg("line50", `RFA_A_STAT, 32'hC0010, 32'h40000);
    test_done("slow_and_line");
    // A random number of energy units lands in both totals.
    axr(`RFA_A_ELIFE);
    v0 = rd;
    axr(`RFA_A_EUSER);
    v1 = rd;
    rnd = lfsr(rnd);
    n = rnd % 13 + 1;
    repeat (n)
    begin
      epulse <= 1'b1;
      wait_cyc(4);
      epulse <= 1'b0;
      rnd = lfsr(rnd);
      wait_cyc(4 + rnd % 8);
    end
    wait_cyc(10);
    chk_reg("elife", `RFA_A_ELIFE, 32'hFFFFFFFF, v0 + n);
    chk_reg("euser", `RFA_A_EUSER, 32'hFFFFFFFF, v1 + n);
    // Buttons only act on a unit with a display fitted.
    axw(`RFA_A_CTRL, 32'h2);
    for (i = 0; i < 13; i++)
    begin
      press(btn[i]);
      chk_reg("screen", `RFA_A_VIEW, 32'h7, scr[i]);
    end
    chk_reg("euser_clr", `RFA_A_EUSER, 32'hFFFFFFFF, 32'h0);
    chk_reg("elife_keep", `RFA_A_ELIFE, 32'hFFFFFFFF, v0 + n);
    test_done("energy_and_screens");
    // Regen-active duty follows random regeneration levels.
    axw(`RFA_A_CTRL, 32'h1);
    repeat (6)
    begin
      rnd = lfsr(rnd);
      regen <= rnd[3];
      wait_cyc(8);
      chk_pin("sel_regen", rnd[3], sel);
      chk_pin("yellow", rnd[3], ly);
    end
    regen <= 1'b0;
    axw(`RFA_A_CTRL, 32'h0);
    test_done("regen_duty");
    // Wait out the precharge interval.
    for (i = 0; i < 150; i++)
    begin
      axr(`RFA_A_STAT);
      if (rd[9] === 1'b0)
        break;
      wait_cyc(1000);
    end
    chk_reg("faults_clear", `RFA_A_STAT, 32'h7FF, 32'h0);
    // A code in progress finishes with its gap, so let one whole precharge code pass.
    wait_cyc(GAP_C + 2 * exp_flashes(`RFA_F_PRE) * exp_width(`RFA_F_PRE) + 20);
    chk_pin("ready_up", 1'b1, rdy);
    chk_pin("red_dark", 1'b0, lr);
    // Over-temperature opens both contacts, blinks and clears by itself.
    axr(`RFA_A_HCNT);
    v0 = rd;
    pf[`RFA_F_OT] <= 1'b1;
    wait_cyc(10);
    chk_pin("sel_ot", 1'b0, sel);
    chk_pin("ready_ot", 1'b0, rdy);
    blink_group(GAP_C / 2, w, n);
    chk_word("ot_flashes", exp_flashes(`RFA_F_OT), n);
    chk_word("fast_width", exp_width(`RFA_F_OT), w);
    chk_reg("hcnt", `RFA_A_HCNT, 32'h7F, v0 + 1);
    chk_reg("rec_faults", `RFA_A_RECF, 32'h7FF, 32'h2);
    pf[`RFA_F_OT] <= 1'b0;
    wait_cyc(10);
    chk_pin("sel_back", 1'b1, sel);
    chk_pin("ready_back", 1'b1, rdy);
    test_done("overtemp");
    // With a display the red lamp stays steady on any fault.
    axw(`RFA_A_CTRL, 32'h2);
    pf[7] <= 1'b1;
    repeat (4)
    begin
      wait_cyc(2000);
      chk_pin("red_steady", 1'b1, lr);
    end
    chk_reg("fview", `RFA_A_VIEW, 32'h0F000000, 32'h08000000);
    pf[7] <= 1'b0;
    wait_cyc(10);
    chk_pin("red_off", 1'b0, lr);
    axw(`RFA_A_CTRL, 32'h0);
    // Feedback undervoltage holds until enable is toggled.
    pf[0] <= 1'b1;
    wait_cyc(10);
    pf[0] <= 1'b0;
    wait_cyc(50);
    chk_reg("fbuv_held", `RFA_A_STAT, 32'h1, 32'h1);
    chk_pin("ready_fbuv", 1'b0, rdy);
    set_en(1'b0);
    set_en(1'b1);
    chk_reg("fbuv_clr", `RFA_A_STAT, 32'h1, 32'h0);
    chk_pin("ready_again", 1'b1, rdy);
    test_done("latching");
    // Disabled unit shows solid red; recall blinks the newest record.
    set_en(1'b0);
    chk_pin("red_solid", 1'b1, lr);
    wait_cyc(3000);
    chk_pin("red_solid", 1'b1, lr);
    want_rc <= 1'b1;
    blink_group(GAP_C / 2, w, n);
    chk_word("recall_flashes", exp_flashes(0), n);
    chk_word("recall_width", exp_width(0), w);
    want_rc <= 1'b0;
    set_en(1'b1);
    test_done("recall");
    report_and_stop();
  end
endmodule // testbench
